// [common/cbam_pkg.sv]
// Shared constants and carrier types of the cell/block/aux measurement block.
package cbam_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (one aligned 32-bit word each).
  // ----------------------------------------------------------------------
  localparam logic [7:0] CBAM_OFS_SCAN    = 8'h00; // Scan control.
  localparam logic [7:0] CBAM_OFS_MEAS1   = 8'h04; // First enable register.
  localparam logic [7:0] CBAM_OFS_MEAS2   = 8'h08; // Second enable register.
  localparam logic [7:0] CBAM_OFS_ACQ     = 8'h0c; // Acquisition config.
  localparam logic [7:0] CBAM_OFS_AUXREF  = 8'h10; // Aux reference control.
  localparam logic [7:0] CBAM_OFS_AUXCFG  = 8'h14; // Aux port config.
  localparam logic [7:0] CBAM_OFS_SETTLE  = 8'h18; // Aux settle delay.
  localparam logic [7:0] CBAM_OFS_POL     = 8'h1c; // Bipolar selection.
  localparam logic [7:0] CBAM_OFS_THRESH  = 8'h20; // Comparator threshold.
  localparam logic [7:0] CBAM_OFS_CELL0   = 8'h40; // First cell result.
  localparam logic [7:0] CBAM_OFS_BLOCK   = 8'h78; // Block result.
  localparam logic [7:0] CBAM_OFS_AUX0    = 8'h7c; // First aux result.

  // ----------------------------------------------------------------------
  // Field positions and sizes.
  // ----------------------------------------------------------------------
  localparam int CBAM_SCAN_START_BIT = 0;  // Start request, self clearing.
  localparam int CBAM_SCAN_FIXED_BIT = 1;  // Fixed-rate oversampling mode.
  localparam int CBAM_SCAN_OVS_LSB   = 2;  // Oversample count, 3 bits.
  localparam int CBAM_SCAN_BUSY_BIT  = 8;  // Acquisition running, read only.
  localparam int CBAM_PACK_EN_BIT    = 14; // Pack measure enable.
  localparam int CBAM_NCELL          = 14; // Cell channels.
  localparam int CBAM_NAUX           = 4;  // Auxiliary channels.
  localparam int CBAM_NCHAN          = 19; // Cells, block, then aux.
  localparam int CBAM_BLOCK_CH       = 14; // Channel index of the block.
  localparam int CBAM_AUX_CH0        = 15; // Channel index of aux 0.
  localparam int CBAM_THRESH_LSB     = 6;  // Threshold sits at the top.

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [1:0]  CBAM_MODE_RST   = 2'h0;  // Automatic bias mode.
  localparam logic [2:0]  CBAM_OVS_RST    = 3'h0;  // One sample.
  localparam logic [13:0] CBAM_RES_RST    = 14'h0000;
  localparam logic [9:0]  CBAM_THRESH_RST = 10'h3ff;

  // Bias output modes.
  localparam logic [1:0] CBAM_BIAS_OFF = 2'h2; // Statically disabled.
  localparam logic [1:0] CBAM_BIAS_ON  = 2'h3; // Statically enabled.

  // ----------------------------------------------------------------------
  // Timing: aux settle step in its own unit, and its clock count.
  // ----------------------------------------------------------------------
  localparam int CBAM_CLK_NS      = 50;   // 20 MHz clock.
  localparam int CBAM_AUX_STEP_NS = 6000; // One settle step, 6 us.
  localparam int CBAM_AUX_STEP_CYC =
    (CBAM_AUX_STEP_NS + CBAM_CLK_NS - 1) / CBAM_CLK_NS; // Rounded up.

  // ----------------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CBAM_IDLE,
    CBAM_PRESETTLE,
    CBAM_CONV,
    CBAM_WAIT
  } cbam_state_t;

  // Conversion request to the analog front end.
  typedef struct packed {
    logic       start;       // One-cycle pulse per sample.
    logic [4:0] channel;     // Channel index 0..18.
    logic       bipolar;     // Convert as signed.
    logic       ratiometric; // Reference is the analog supply.
  } cbam_conv_req_t;

  // Conversion answer from the analog front end.
  typedef struct packed {
    logic        valid; // One-cycle pulse with data.
    logic [11:0] data;  // 12-bit sample.
  } cbam_conv_rsp_t;

endpackage : cbam_pkg

// [src/cbam_measure.sv]
// Measurement sequencer, averaging and register file of the block.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// One acquisition runs at a time. A start write loads the settle counter,
// then the sequencer walks every channel in index order (cells, block,
// aux) and averages the enabled ones. A result register changes only when
// the last sample of its channel is in, so software never sees a partial
// sum, whatever the moment of its read.
module cbam_measure
  import cbam_pkg::*;
(
  input  wire logic           clk,             // 20 MHz clock.
  input  wire logic           sys_rst,         // Synchronous reset.
  input  wire logic [7:0]     avs_address,     // Byte address.
  input  wire logic           avs_read,        // Read request.
  input  wire logic           avs_write,       // Write request.
  input  wire logic [31:0]    avs_writedata,   // Write data.
  output logic      [31:0]    avs_readdata,    // Read data.
  output logic                avs_waitrequest, // Stall.
  output cbam_conv_req_t      conv_req,        // To the converter.
  input  wire cbam_conv_rsp_t conv_rsp,        // From the converter.
  output logic                pack_divider_close, // Block divider switch.
  output logic                thermistor_bias_output, // Bias switch.
  output logic                acq_busy         // Acquisition running.
);

  // ----------------------------------------------------------------------
  // State of the module.
  // ----------------------------------------------------------------------
  typedef struct packed {
    cbam_state_t                  st;       // Sequencer state.
    logic                         ack;      // Bus answer phase.
    logic [31:0]                  rdata;    // Registered read data.
    logic                         fixed;    // Deterministic timing mode.
    logic [2:0]                   ovs;      // Log2 of sample count.
    logic [13:0]                  cell_en;  // Cell enables.
    logic                         pack_en;  // Block enable.
    logic [3:0]                   aux_en;   // Aux enables.
    logic [1:0]                   mode;     // Bias output mode.
    logic [3:0]                   refsel;   // 1 = absolute reference.
    logic [3:0]                   gpio;     // Port used as digital.
    logic [9:0]                   settle;   // Settle field.
    logic [13:0]                  pol;      // Bipolar selection.
    logic [9:0]                   thresh;   // Comparator threshold.
    logic [4:0]                   chan;     // Current channel.
    logic [7:0]                   smp;      // Samples taken.
    logic [19:0]                  acc;      // Running sum.
    logic [19:0]                  wait_cnt; // Settle cycles left.
    logic                         start;    // Conversion start pulse.
    logic [CBAM_NCHAN-1:0][13:0]  res;      // Results.
  } cbam_regs_t;

  cbam_regs_t s_q; // Registered state.
  cbam_regs_t s_d; // Next state.

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------

  // Tells whether a channel takes part in the acquisition.
  function automatic logic cbam_chan_on(input cbam_regs_t s,
                                        input logic [4:0] ch);
    logic on;
    on = 1'b0;
    if (ch < 5'(CBAM_NCELL)) begin
      on = s.cell_en[ch[3:0]];
    end else if (ch == 5'(CBAM_BLOCK_CH)) begin
      on = s.pack_en;
    end else if (ch < 5'(CBAM_NCHAN)) begin
      // A port used as digital is never measured.
      on = s.aux_en[2'(ch - 5'(CBAM_AUX_CH0))] &
           ~s.gpio[2'(ch - 5'(CBAM_AUX_CH0))];
    end
    return on;
  endfunction : cbam_chan_on

  // Total settle cycles: field times step times enabled aux ports not used as digital.
  // The worst case, 1023 steps of 120 cycles on all four ports, still fits
  // the 20-bit counter, so no saturation logic is needed.
  function automatic logic [19:0] cbam_settle_cycles(input cbam_regs_t s);
    logic [2:0]  n;
    logic [3:0]  act;
    n   = 3'h0;
    act = s.aux_en & ~s.gpio;
    for (int i = 0; i < CBAM_NAUX; i++) begin
      n = n + 3'(act[i]);
    end
    return 20'(s.settle) * 20'(CBAM_AUX_STEP_CYC) * 20'(n);
  endfunction : cbam_settle_cycles

  // Register read multiplexer.
  function automatic logic [31:0] cbam_read(input cbam_regs_t s,
                                            input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000; // Unmapped and reserved bits read zero.
    case (a)
      CBAM_OFS_SCAN: begin
        r[CBAM_SCAN_FIXED_BIT]                 = s.fixed;
        r[CBAM_SCAN_OVS_LSB +: 3]              = s.ovs;
        r[CBAM_SCAN_BUSY_BIT]                  = (s.st != CBAM_IDLE);
      end
      CBAM_OFS_MEAS1: begin
        r[13:0]             = s.cell_en;
        r[CBAM_PACK_EN_BIT] = s.pack_en;
      end
      CBAM_OFS_MEAS2:  r[3:0]  = s.aux_en;
      CBAM_OFS_ACQ:    r[1:0]  = s.mode;
      CBAM_OFS_AUXREF: r[3:0]  = s.refsel;
      CBAM_OFS_AUXCFG: r[3:0]  = s.gpio;
      CBAM_OFS_SETTLE: r[9:0]  = s.settle;
      CBAM_OFS_POL:    r[13:0] = s.pol;
      // Threshold aligned to the top of the 16-bit word.
      CBAM_OFS_THRESH: r[15:CBAM_THRESH_LSB] = s.thresh;
      default: begin
        // Results sit in bits 15:2 with the two low bits zero.
        for (int i = 0; i < CBAM_NCHAN; i++) begin
          if (a == CBAM_OFS_CELL0 + 8'(4 * i)) begin
            r[15:2] = s.res[i];
          end
        end
      end
    endcase
    return r;
  endfunction : cbam_read

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------

  // Bus slave, register writes and the acquisition sequencer.
  always_comb begin
    logic        req;
    logic        wr;
    logic        on;
    logic        aux_ch;
    logic [19:0] ext;
    logic [19:0] sum;
    logic [21:0] avg;
    req    = avs_read | avs_write;
    wr     = s_q.ack & avs_write;
    on     = cbam_chan_on(s_q, s_q.chan);
    aux_ch = (s_q.chan >= 5'(CBAM_AUX_CH0));
    ext    = 20'h00000;
    sum    = 20'h00000;
    avg    = 22'h000000;
    s_d    = s_q;
    s_d.start = 1'b0;

    // One wait state: answer is given on the second cycle of a request.
    // Read data are captured on the first cycle so that they stand through
    // the whole answer cycle; the cost is that a read sees the registers
    // as they were one cycle before the answer.
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdata = cbam_read(s_q, avs_address);
    end

    // Register writes take effect on the accepting edge.
    if (wr) begin
      case (avs_address)
        CBAM_OFS_SCAN: begin
          s_d.fixed = avs_writedata[CBAM_SCAN_FIXED_BIT];
          s_d.ovs   = avs_writedata[CBAM_SCAN_OVS_LSB +: 3];
        end
        CBAM_OFS_MEAS1: begin
          s_d.cell_en = avs_writedata[13:0];
          s_d.pack_en = avs_writedata[CBAM_PACK_EN_BIT];
        end
        CBAM_OFS_MEAS2:  s_d.aux_en = avs_writedata[3:0];
        CBAM_OFS_ACQ:    s_d.mode   = avs_writedata[1:0];
        CBAM_OFS_AUXREF: s_d.refsel = avs_writedata[3:0];
        CBAM_OFS_AUXCFG: s_d.gpio   = avs_writedata[3:0];
        CBAM_OFS_SETTLE: s_d.settle = avs_writedata[9:0];
        CBAM_OFS_POL:    s_d.pol    = avs_writedata[13:0];
        CBAM_OFS_THRESH: s_d.thresh = avs_writedata[15:CBAM_THRESH_LSB];
        default: begin
          // Results and unmapped words ignore writes.
        end
      endcase
    end

    // The settle counter runs down in every state.
    // Letting it run in every state is what allows a free-running scan to
    // overlap the settle time with the cell and block channels.
    if (s_q.wait_cnt != 20'h00000) begin
      s_d.wait_cnt = s_q.wait_cnt - 20'h00001;
    end

    case (s_q.st)
      CBAM_IDLE: begin
        // A start while busy is ignored; configuration is taken as it
        // stands at this edge.
        // Limitation: the settle time counts the aux enables as they stood
        // before this write, so enables must be written before the start.
        if (wr && avs_address == CBAM_OFS_SCAN &&
            avs_writedata[CBAM_SCAN_START_BIT]) begin
          s_d.chan     = 5'h00;
          s_d.wait_cnt = cbam_settle_cycles(s_q);
          // Fixed-rate scans settle first, others in parallel.
          s_d.st = avs_writedata[CBAM_SCAN_FIXED_BIT] ?
                   CBAM_PRESETTLE : CBAM_CONV;
        end
      end
      CBAM_PRESETTLE: begin
        // Fixed-rate scans hold here so that the spacing of their samples
        // never depends on the settle setting.
        if (s_q.wait_cnt == 20'h00000) begin
          s_d.st = CBAM_CONV;
        end
      end
      CBAM_CONV: begin
        if (s_q.chan == 5'(CBAM_NCHAN)) begin
          // Every channel visited: the acquisition ends.
          s_d.st = CBAM_IDLE;
        end else if (!on) begin
          // Skipped channel keeps its old result.
          s_d.chan = s_q.chan + 5'h01;
        end else if (!(aux_ch && s_q.wait_cnt != 20'h00000)) begin
          // Cells and block run while aux settling elapses.
          s_d.acc   = 20'h00000;
          s_d.smp   = 8'h00;
          s_d.start = 1'b1;
          s_d.st    = CBAM_WAIT;
        end
        // Otherwise an enabled aux channel stalls here until its settle
        // time has run out.
      end
      CBAM_WAIT: begin
        if (conv_rsp.valid) begin
          // Sign-extend only bipolar cell channels.
          if (s_q.chan < 5'(CBAM_NCELL) && s_q.pol[s_q.chan[3:0]]) begin
            ext = {{8{conv_rsp.data[11]}}, conv_rsp.data};
          end else begin
            ext = {8'h00, conv_rsp.data};
          end
          sum       = s_q.acc + ext;
          s_d.acc   = sum;
          s_d.smp   = s_q.smp + 8'h01;
          if (s_q.smp + 8'h01 == 8'(1 << s_q.ovs)) begin
            // Average scaled to 14 bits, 5 V over 16384.
            avg = 22'($signed({sum, 2'b00}) >>> s_q.ovs);
            s_d.res[s_q.chan] = avg[13:0];
            s_d.chan = s_q.chan + 5'h01;
            s_d.st   = CBAM_CONV;
          end else begin
            // More samples to go: ask for the next one at once.
            s_d.start = 1'b1;
          end
        end
      end
      default: begin
        s_d.st = CBAM_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------

  // Every field returns to a constant under reset.
  // A reset in mid-acquisition drops the partial sum together with all
  // stored results; software has to start a fresh acquisition after it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.st      <= CBAM_IDLE;
      s_q.ovs     <= CBAM_OVS_RST;
      s_q.mode    <= CBAM_MODE_RST;
      s_q.thresh  <= CBAM_THRESH_RST;
      s_q.res     <= {CBAM_NCHAN{CBAM_RES_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------

  // Bias switch and divider follow the mode and the acquisition.
  always_comb begin
    acq_busy           = (s_q.st != CBAM_IDLE);
    pack_divider_close = acq_busy & s_q.pack_en;
    case (s_q.mode)
      CBAM_BIAS_OFF: thermistor_bias_output = 1'b0;
      CBAM_BIAS_ON:  thermistor_bias_output = 1'b1;
      default:       thermistor_bias_output = acq_busy;
    endcase
    // Waitrequest is combinational so that the second cycle of every
    // request answers without a further registered delay.
    avs_waitrequest     = (avs_read | avs_write) & ~s_q.ack;
    avs_readdata        = s_q.rdata;
    conv_req.start      = s_q.start;
    conv_req.channel    = s_q.chan;
    // Only cell channels can carry a bus bar, so only they are signed.
    conv_req.bipolar    = (s_q.chan < 5'(CBAM_NCELL)) &
                          s_q.pol[s_q.chan[3:0]];
    // Ratiometric aux converts against the supply.
    conv_req.ratiometric = (s_q.chan >= 5'(CBAM_AUX_CH0)) &&
                           (s_q.chan < 5'(CBAM_NCHAN)) &&
                           !s_q.refsel[2'(s_q.chan - 5'(CBAM_AUX_CH0))];
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Switch outputs against mode and acquisition.
  divider_idle_a: assert property (!acq_busy |-> !pack_divider_close)
    else $error("block divider closed outside acquisition");
  bias_off_a: assert property (s_q.mode == CBAM_BIAS_OFF |->
    !thermistor_bias_output)
    else $error("bias on in static off mode");
  bias_on_a: assert property (s_q.mode == CBAM_BIAS_ON |->
    thermistor_bias_output)
    else $error("bias off in static on mode");
  bias_auto_a: assert property (s_q.mode[1] == 1'b0 |->
    thermistor_bias_output == acq_busy)
    else $error("automatic bias does not follow acquisition");
  // Sequencer order and result updates.
  fixed_settle_a: assert property (s_q.fixed && s_q.wait_cnt != 0
    && acq_busy |-> !conv_req.start)
    else $error("conversion before settle in fixed mode");
  gpio_skip_a: assert property (conv_req.start &&
    conv_req.channel >= 5'(CBAM_AUX_CH0) |->
    !s_q.gpio[2'(conv_req.channel - 5'(CBAM_AUX_CH0))])
    else $error("digital port was measured");
  cell_keep_a: assert property (!s_q.cell_en[0] |=>
    $stable(s_q.res[0]) || $past(s_q.cell_en[0]))
    else $error("disabled cell result changed");
  result_hold_a: assert property (s_q.st != CBAM_WAIT |=>
    $stable(s_q.res))
    else $error("result changed outside averaging end");
  // Register bus answer.
  low_bits_a: assert property (s_q.ack && avs_read &&
    avs_address >= CBAM_OFS_CELL0 |-> avs_readdata[1:0] == 2'b00)
    else $error("result low bits not zero");
  bus_answer_a: assert property ((avs_read || avs_write) |->
    ##[0:1] !avs_waitrequest)
    else $error("bus answer late");

  // Main scenarios that the bench is expected to reach.
  acq_done_c: cover property (acq_busy ##1 !acq_busy);
  aux_conv_c: cover property (conv_req.start && conv_req.ratiometric);
  parallel_settle_c: cover property (conv_req.start &&
    s_q.wait_cnt != 0 && !s_q.fixed);
  block_conv_c: cover property (conv_req.start &&
    conv_req.channel == 5'(CBAM_BLOCK_CH));

endmodule : cbam_measure

// [tb/cbam_afe_model.sv]
// Behavioural converter front end that answers sample requests.
`timescale 1ns/1ps
module cbam_afe_model
  import cbam_pkg::*;
(
  input  wire logic           clk,      // Shared clock.
  input  wire logic           busy,     // Acquisition running.
  input  wire cbam_conv_req_t conv_req, // Sample request.
  input  wire logic [11:0]    ofs,      // Offset added to samples.
  input  wire logic [3:0]     lat,      // Extra answer delay.
  output cbam_conv_rsp_t      conv_rsp  // Sample answer.
);
  logic [11:0] last_q; // Last sample sent.
  logic [4:0]  ch_q;   // Channel of the last request.
  logic [11:0] k_q;    // Sample index within a channel.

  // ------------------------------------------------------------
  // One answer per start; the sample rises with its index so that
  // averaging can be told from a single sample. Between answers
  // the data lines carry the inverse of the last sample.
  // ------------------------------------------------------------
  initial begin
    conv_rsp = '0;
    ch_q     = 5'h1f;
    k_q      = 12'h000;
  end
  always @(posedge clk) begin
    if (busy !== 1'b1) begin
      ch_q = 5'h1f;
    end
    if (conv_req.start === 1'b1) begin
      k_q  = (conv_req.channel == ch_q) ? k_q + 12'h001 : 12'h000;
      ch_q = conv_req.channel;
      repeat (lat) @(posedge clk);
      last_q = {ch_q, 7'h00} + ofs + k_q;
      conv_rsp <= '{valid: 1'b1, data: last_q};
      @(posedge clk);
      conv_rsp <= '{valid: 1'b0, data: ~last_q};
    end
  end
endmodule : cbam_afe_model

// [tb/cbam_measure_tb_top.sv]
// Self-checking bench of the measurement block.
`timescale 1ns/1ps
module cbam_measure_tb_top
  import cbam_pkg::*;
;
  logic           clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]     avs_address;       // Byte address.
  logic [31:0]    avs_writedata, avs_readdata, rdat;
  cbam_conv_req_t conv_req;          // Request to the model.
  cbam_conv_rsp_t conv_rsp;          // Answer of the model.
  logic           pack_divider_close, thermistor_bias_output, acq_busy;
  logic [11:0]    ofs;               // Model sample offset.
  logic [3:0]     lat;               // Model answer delay.
  logic           div_seen, bias_or; // Seen high while busy.
  logic [18:0]    seen, rat_seen, bip_seen; // Per-channel records.
  int             cyc, first_cyc, err_count, check_count;

  always #25 clk = ~clk;

  cbam_measure u_dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_req(conv_req), .conv_rsp(conv_rsp),
    .pack_divider_close(pack_divider_close),
    .thermistor_bias_output(thermistor_bias_output),
    .acq_busy(acq_busy));
  cbam_afe_model u_afe (.clk(clk), .busy(acq_busy),
    .conv_req(conv_req), .ofs(ofs), .lat(lat), .conv_rsp(conv_rsp));

  // ------------------------------------------------------------
  // Monitor: what the block asks of the converter while busy.
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (acq_busy === 1'b1) begin
      cyc      <= cyc + 1;
      div_seen <= div_seen | pack_divider_close;
      bias_or  <= bias_or | thermistor_bias_output;
      if (conv_req.start === 1'b1) begin
        if (seen == '0) first_cyc <= cyc;
        seen[conv_req.channel]     <= 1'b1;
        rat_seen[conv_req.channel] <= conv_req.ratiometric;
        bip_seen[conv_req.channel] <= conv_req.bipolar;
      end
    end
  end

  // ------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------
  // Expected register: 14-bit average of base+k over 2^n samples.
  function automatic logic [31:0] exp_res(input logic [4:0] ch,
      input logic [11:0] o, input logic [2:0] n);
    logic [15:0] b;
    b = {4'h0, ch, 7'h00} + {4'h0, o};
    return {16'h0, (b << 4) + (16'h0008 << n) - 16'h0008};
  endfunction : exp_res

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; holds the request until waitrequest is low.
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rdat = avs_readdata;
    if (n >= 50) err_count++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rdc

  // Starts an acquisition and waits, bounded, until it ends.
  task automatic run(input logic [31:0] scan);
    int n;
    n = 0;
    div_seen = 1'b0;
    bias_or  = 1'b0;
    seen     = '0;
    cyc      = 0;
    bus(1'b1, CBAM_OFS_SCAN, scan | 32'h1);
    chk({31'h0, acq_busy}, 32'h1);
    while (acq_busy !== 1'b1 && n < 5) begin
      @(posedge clk);
      n++;
    end
    while (acq_busy !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) err_count++;
  endtask : run

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0; sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h0; ofs = 12'h003;
    lat = 4'h3; err_count = 0; check_count = 0; cyc = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset values, read-only results and an unmapped address.
    rdc(CBAM_OFS_THRESH, 32'h0000ffc0);
    rdc(8'hf0, 32'h0);
    chk({31'h0, thermistor_bias_output}, 32'h0);
    bus(1'b1, CBAM_OFS_THRESH, 32'h8000);
    rdc(CBAM_OFS_THRESH, 32'h00008000);
    bus(1'b1, CBAM_OFS_CELL0, 32'h1234);
    rdc(CBAM_OFS_CELL0, 32'h0);
    $display("test reset done");
    // Cell 0 as a bus bar plus the block, one sample each.
    bus(1'b1, CBAM_OFS_MEAS1, 32'h4001);
    bus(1'b1, CBAM_OFS_POL, 32'h1);
    run(32'h0);
    rdc(CBAM_OFS_CELL0, exp_res(5'd0, 12'h3, 3'h0));
    rdc(CBAM_OFS_BLOCK, exp_res(5'd14, 12'h3, 3'h0));
    chk({31'h0, div_seen}, 32'h1);
    chk({31'h0, pack_divider_close}, 32'h0);
    chk({31'h0, bip_seen[0]}, 32'h1);
    $display("test cell_block done");
    // Cell 1 alone at the largest oversampling, prompt answers.
    ofs <= 12'h005;
    lat <= 4'h0;
    bus(1'b1, CBAM_OFS_MEAS1, 32'h2);
    run(32'h1c);
    rdc(CBAM_OFS_CELL0 + 8'h04, exp_res(5'd1, 12'h5, 3'h7));
    rdc(CBAM_OFS_CELL0, exp_res(5'd0, 12'h3, 3'h0));
    rdc(CBAM_OFS_BLOCK, exp_res(5'd14, 12'h3, 3'h0));
    chk({31'h0, div_seen | seen[14]}, 32'h0);
    $display("test retain done");
    // Aux in fixed-rate mode: port 2 digital, port 0 absolute.
    lat <= 4'h2;
    bus(1'b1, CBAM_OFS_MEAS1, 32'h0);
    bus(1'b1, CBAM_OFS_MEAS2, 32'hf);
    bus(1'b1, CBAM_OFS_AUXREF, 32'h1);
    bus(1'b1, CBAM_OFS_AUXCFG, 32'h4);
    bus(1'b1, CBAM_OFS_SETTLE, 32'h1);
    rdc(CBAM_OFS_SETTLE, 32'h1);
    run(32'h2);
    chk({31'h0, first_cyc inside {[375:379]}}, 32'h1);
    rdc(CBAM_OFS_AUX0, exp_res(5'd15, 12'h5, 3'h0));
    rdc(CBAM_OFS_AUX0 + 8'h04, exp_res(5'd16, 12'h5, 3'h0));
    rdc(CBAM_OFS_AUX0 + 8'h08, 32'h0);
    chk({31'h0, seen[17]}, 32'h0);
    chk({30'h0, rat_seen[16:15]}, 32'h2);
    $display("test aux done");
    // Free-running scan: cell 0 converts while the aux settle elapses.
    bus(1'b1, CBAM_OFS_MEAS1, 32'h1);
    run(32'h0);
    chk({31'h0, first_cyc inside {[0:3]}}, 32'h1);
    chk({31'h0, cyc >= 360}, 32'h1);
    rdc(CBAM_OFS_CELL0, exp_res(5'd0, 12'h5, 3'h0));
    $display("test free_run done");
    // Every bias mode, idle and during an acquisition of cell 0 alone.
    bus(1'b1, CBAM_OFS_MEAS2, 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, CBAM_OFS_ACQ, 32'(m));
      chk({31'h0, thermistor_bias_output}, {31'h0, m == 3});
      run(32'h0);
      chk({31'h0, bias_or}, {31'h0, m != 2});
    end
    $display("test bias done");
    stop_test();
  end
endmodule : cbam_measure_tb_top
